// ==== anpns_assertions.sv ====
`timescale 1ns/1ps
`default_nettype none
module anpns_assertions (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic local_more_pages_flag,
  input wire logic tx_page_sent,
  input wire logic tx_more_pages,
  input wire logic tx_toggle
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  property p_toggle_flip;
    tx_page_sent |=> tx_toggle != $past(tx_toggle);
  endproperty
  a_toggle_flip: assert property (p_toggle_flip)
    else $error("toggle did not flip after a sent page");
  property p_toggle_hold;
    !tx_page_sent |=> $stable(tx_toggle);
  endproperty
  a_toggle_hold: assert property (p_toggle_hold)
    else $error("toggle moved without a sent page");
  property p_more_follow;
    1'b1 |=> tx_more_pages == $past(local_more_pages_flag);
  endproperty
  a_more_follow: assert property (p_more_follow)
    else $error("sent more-pages flag not the local flag");
  property p_reset_clear;
    $past(sys_rst) |-> !tx_toggle && !tx_more_pages;
  endproperty
  a_reset_clear: assert property (p_reset_clear)
    else $error("transmit flags not cleared by reset");
  property p_toggle_cause;
    $changed(tx_toggle) |-> $past(tx_page_sent);
  endproperty
  a_toggle_cause: assert property (p_toggle_cause)
    else $error("toggle changed with no sent page before it");
  property p_more_rise;
    $rose(tx_more_pages) |-> $past(local_more_pages_flag);
  endproperty
  a_more_rise: assert property (p_more_rise)
    else $error("more-pages flag rose without the local flag");
endmodule
bind anpns_top anpns_assertions i_chk (
  .clk(clk), .sys_rst(sys_rst), .local_more_pages_flag(local_more_pages_flag),
  .tx_page_sent(tx_page_sent), .tx_more_pages(tx_more_pages), .tx_toggle(tx_toggle)
);
`default_nettype wire

// ==== anpns_defines.vh ====
`ifndef ANPNS_DEFINES_VH
`define ANPNS_DEFINES_VH

// management device address of the auto-negotiation space
`define ANPNS_DEVAD          5'h07

// register offsets
`define ANPNS_OFS_PNP_WORD0  16'h0019
`define ANPNS_OFS_PNP_WORD1  16'h001a
`define ANPNS_OFS_PNP_WORD2  16'h001b
`define ANPNS_OFS_BP_STATUS  16'h0030

// reset values
`define ANPNS_RST_PNP        16'h0000
`define ANPNS_RST_BP_STATUS  16'h0001
`define ANPNS_RST_ADDR       16'h0000

// first partner next page word fields
`define ANPNS_BIT_MORE_PAGES 15
`define ANPNS_BIT_PAGE_ACK   14
`define ANPNS_BIT_MSG_PAGE   13
`define ANPNS_BIT_PAGE_ACK2  12
`define ANPNS_BIT_TOGGLE     11
`define ANPNS_CODE_MSB       10
`define ANPNS_CODE_LSB       0

// received code word slices
`define ANPNS_CW0_MSB        15
`define ANPNS_CW1_MSB        31
`define ANPNS_CW1_LSB        16
`define ANPNS_CW2_MSB        47
`define ANPNS_CW2_LSB        32

// backplane status fields
`define ANPNS_BIT_KR_FEC     4
`define ANPNS_BIT_KR         3
`define ANPNS_BIT_KX         1
`define ANPNS_BIT_CAPABLE    0

// management frame opcodes
`define ANPNS_OP_ADDR        2'b00
`define ANPNS_OP_WRITE       2'b01
`define ANPNS_OP_RDINC       2'b10
`define ANPNS_OP_READ        2'b11

// management frame timing, in data clock edges
`define ANPNS_PREAMBLE_LEN   6'h20
`define ANPNS_EDGE_HDR_LAST  5'h0d
`define ANPNS_EDGE_TA0       5'h0e
`define ANPNS_EDGE_TA1       5'h0f
`define ANPNS_EDGE_LAST      5'h1f

`endif

// ==== anpns_host.sv ====
`timescale 1ns/1ps
`default_nettype none
module anpns_host (
  input  wire logic clk,
  input  wire logic mdio_out,
  input  wire logic mdio_oe,
  output var  logic mdc,
  output wire logic mdio_in
);
  logic drv;
  // pull-up: a released line reads one
  assign mdio_in = mdio_oe ? mdio_out : drv;
  initial begin
    mdc = 1'b0;
    drv = 1'b1;
  end
  // mdc stands low between frames
  task automatic frame(input logic [1:0] op, input logic [4:0] dev, input logic [15:0] d,
                       output logic [15:0] q);
    logic [63:0] w;
    w = {32'hffff_ffff, 2'b00, op, 5'h00, dev, 2'b10, d};
    // read frames: turnaround and data released
    if (op[1]) w[17:0] = 18'h3ffff;
    q = 16'h0000;
    for (int i = 63; i >= 0; i--) begin
      @(posedge clk);
      drv <= w[i];
      repeat (5) @(posedge clk);
      mdc <= 1'b1;
      if (i < 16) q = {q[14:0], mdio_in};
      repeat (5) @(posedge clk);
      mdc <= 1'b0;
    end
    // released line goes back to the pull-up level
    drv <= 1'b1;
  endtask
endmodule
`default_nettype wire

// ==== anpns_mdio.v ====
`timescale 1ns/1ps
`default_nettype none
`include "anpns_defines.vh"

module anpns_mdio #(
  parameter [4:0] PORT_ADDR = 5'h00
) (
  input  wire        clk,
  input  wire        sys_rst,
  input  wire        mdc,
  input  wire        mdio_in,
  output reg         mdio_out,
  output reg         mdio_oe,
  output reg  [1:0]  frame_op,
  output reg         rd_req,
  input  wire [15:0] rd_data,
  output reg         cmd_valid,
  output reg  [15:0] cmd_data
);

  localparam [3:0] ST_IDLE = 4'h1;
  localparam [3:0] ST_HDR  = 4'h2;
  localparam [3:0] ST_TA   = 4'h4;
  localparam [3:0] ST_DATA = 4'h8;

  reg        mdc_s1;
  reg        mdc_s2;
  reg        mdc_s3;
  reg        mdio_s1;
  reg        mdio_s2;
  reg [3:0]  state;
  reg [5:0]  ones;
  reg [4:0]  cnt;
  reg [12:0] hdr;
  reg [15:0] sh;
  reg        mine;

  wire        rise     = mdc_s2 & ~mdc_s3;
  wire        bit_in   = mdio_s2;
  wire [13:0] hdr_full = {hdr, bit_in};
  wire        is_read  = frame_op[1];

  always @(posedge clk) begin
    if (sys_rst) begin
      mdc_s1  <= 1'b0;
      mdc_s2  <= 1'b0;
      mdc_s3  <= 1'b0;
      mdio_s1 <= 1'b1;
      mdio_s2 <= 1'b1;
    end else begin
      mdc_s1  <= mdc;
      mdc_s2  <= mdc_s1;
      mdc_s3  <= mdc_s2;
      mdio_s1 <= mdio_in;
      mdio_s2 <= mdio_s1;
    end
  end

  always @(posedge clk) begin
    if (sys_rst) begin
      state     <= ST_IDLE;
      ones      <= 6'h00;
      cnt       <= 5'h00;
      hdr       <= 13'h0000;
      sh        <= 16'h0000;
      mine      <= 1'b0;
      frame_op  <= 2'b00;
      rd_req    <= 1'b0;
      cmd_valid <= 1'b0;
      cmd_data  <= 16'h0000;
      mdio_out  <= 1'b1;
      mdio_oe   <= 1'b0;
    end else begin
      rd_req    <= 1'b0;
      cmd_valid <= 1'b0;
      if (rise) begin
        case (state)
          ST_IDLE: begin
            if (bit_in) begin
              if (ones != `ANPNS_PREAMBLE_LEN) begin
                ones <= ones + 6'h01;
              end
            end else begin
              ones <= 6'h00;
              if (ones == `ANPNS_PREAMBLE_LEN) begin
                state <= ST_HDR;
                cnt   <= 5'h01;
                hdr   <= 13'h0000;
              end
            end
          end
          ST_HDR: begin
            hdr <= hdr_full[12:0];
            cnt <= cnt + 5'h01;
            if (cnt == `ANPNS_EDGE_HDR_LAST) begin
              // start bits, port and device must all match
              mine     <= (hdr_full[13:12] == 2'b00) && (hdr_full[9:5] == PORT_ADDR) &&
                          (hdr_full[4:0] == `ANPNS_DEVAD);
              frame_op <= hdr_full[11:10];
              rd_req   <= (hdr_full[13:12] == 2'b00) && (hdr_full[9:5] == PORT_ADDR) &&
                          (hdr_full[4:0] == `ANPNS_DEVAD) && hdr_full[11];
              state    <= ST_TA;
            end
          end
          ST_TA: begin
            cnt <= cnt + 5'h01;
            if (cnt == `ANPNS_EDGE_TA0) begin
              if (mine && is_read) begin
                mdio_oe  <= 1'b1;
                mdio_out <= 1'b0;
              end
            end else begin
              state <= ST_DATA;
              if (mine && is_read) begin
                mdio_out <= rd_data[15];
                sh       <= {rd_data[14:0], 1'b0};
              end else begin
                sh <= 16'h0000;
              end
            end
          end
          ST_DATA: begin
            cnt <= cnt + 5'h01;
            if (cnt == `ANPNS_EDGE_LAST) begin
              state    <= ST_IDLE;
              ones     <= 6'h00;
              mdio_oe  <= 1'b0;
              mdio_out <= 1'b1;
              if (mine && !is_read) begin
                cmd_valid <= 1'b1;
                cmd_data  <= {sh[14:0], bit_in};
              end
            end else if (mine && is_read) begin
              mdio_out <= sh[15];
              sh       <= {sh[14:0], 1'b0};
            end else begin
              sh <= {sh[14:0], bit_in};
            end
          end
          default: begin
            state   <= ST_IDLE;
            mdio_oe <= 1'b0;
          end
        endcase
      end
    end
  end

endmodule

`default_nettype wire

// ==== anpns_top.v ====
`timescale 1ns/1ps
`default_nettype none
`include "anpns_defines.vh"

module anpns_top #(
  parameter [4:0] PORT_ADDR = 5'h00
) (
  input  wire        clk,
  input  wire        sys_rst,
  input  wire        mdc,
  input  wire        mdio_in,
  output wire        mdio_out,
  output wire        mdio_oe,
  input  wire        rx_page_valid,
  input  wire [47:0] rx_page,
  input  wire        resolved_kr_with_fec,
  input  wire        resolved_kr,
  input  wire        resolved_kx,
  input  wire        local_more_pages_flag,
  input  wire        tx_page_sent,
  output reg         tx_more_pages,
  output reg         tx_toggle
);

  wire [1:0]  frame_op;
  wire        rd_req;
  wire        cmd_valid;
  wire [15:0] cmd_data;

  reg  [15:0] mmd_addr;
  reg  [15:0] rd_data;
  reg  [15:0] pnp_word0;
  reg  [15:0] pnp_word1;
  reg  [15:0] pnp_word2;
  reg  [15:0] pnp_snap1;
  reg  [15:0] pnp_snap2;
  reg         resolved_kr_with_fec_q;
  reg         resolved_kr_q;
  reg         resolved_kx_q;
  reg  [15:0] bp_status;
  reg  [15:0] next_rd_data;
  reg  [15:0] next_mmd_addr;
  reg         next_tx_toggle;

  // fields of the received code word
  wire        partner_more_pages_flag   = rx_page[15];
  wire        partner_page_ack          = rx_page[14];
  wire        partner_message_page_flag = rx_page[13];
  wire        partner_page_ack_second   = rx_page[12];
  wire        partner_toggle_bit        = rx_page[11];
  wire [10:0] partner_code_field        = rx_page[10:0];
  wire [15:0] partner_code_word_mid     = rx_page[`ANPNS_CW1_MSB:`ANPNS_CW1_LSB];
  wire [15:0] partner_code_word_high    = rx_page[`ANPNS_CW2_MSB:`ANPNS_CW2_LSB];

  // frame kinds that may move the address register
  wire        addr_frame = cmd_valid & (frame_op == `ANPNS_OP_ADDR);
  wire        post_inc   = rd_req & (frame_op == `ANPNS_OP_RDINC);

  // decode of the current register address
  wire        hit_word0  = (mmd_addr == `ANPNS_OFS_PNP_WORD0);
  wire        hit_word1  = (mmd_addr == `ANPNS_OFS_PNP_WORD1);
  wire        hit_word2  = (mmd_addr == `ANPNS_OFS_PNP_WORD2);
  wire        hit_status = (mmd_addr == `ANPNS_OFS_BP_STATUS);

  anpns_mdio #(
    .PORT_ADDR (PORT_ADDR)
  ) u_mdio (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .mdc       (mdc),
    .mdio_in   (mdio_in),
    .mdio_out  (mdio_out),
    .mdio_oe   (mdio_oe),
    .frame_op  (frame_op),
    .rd_req    (rd_req),
    .rd_data   (rd_data),
    .cmd_valid (cmd_valid),
    .cmd_data  (cmd_data)
  );

  // received next page code word, taken whole so words never mix pages
  always @(posedge clk) begin
    if (sys_rst) begin
      pnp_word0 <= `ANPNS_RST_PNP;
    end else if (rx_page_valid) begin
      pnp_word0[`ANPNS_BIT_MORE_PAGES]           <= partner_more_pages_flag;
      pnp_word0[`ANPNS_BIT_PAGE_ACK]             <= partner_page_ack;
      pnp_word0[`ANPNS_BIT_MSG_PAGE]             <= partner_message_page_flag;
      pnp_word0[`ANPNS_BIT_PAGE_ACK2]            <= partner_page_ack_second;
      pnp_word0[`ANPNS_BIT_TOGGLE]               <= partner_toggle_bit;
      pnp_word0[`ANPNS_CODE_MSB:`ANPNS_CODE_LSB] <= partner_code_field;
    end
  end

  always @(posedge clk) begin
    if (sys_rst) begin
      pnp_word1 <= `ANPNS_RST_PNP;
    end else if (rx_page_valid) begin
      pnp_word1 <= partner_code_word_mid;
    end
  end

  always @(posedge clk) begin
    if (sys_rst) begin
      pnp_word2 <= `ANPNS_RST_PNP;
    end else if (rx_page_valid) begin
      pnp_word2 <= partner_code_word_high;
    end
  end

  // negotiated technology, bit 0 fixed high, others zero
  always @(posedge clk) begin
    if (sys_rst) begin
      resolved_kr_with_fec_q <= 1'b0;
      resolved_kr_q          <= 1'b0;
      resolved_kx_q          <= 1'b0;
    end else begin
      resolved_kr_with_fec_q <= resolved_kr_with_fec;
      resolved_kr_q          <= resolved_kr;
      resolved_kx_q          <= resolved_kx;
    end
  end

  always @* begin
    bp_status                       = `ANPNS_RST_BP_STATUS;
    bp_status[15:5]                 = 11'h000;
    bp_status[2]                    = 1'b0;
    bp_status[`ANPNS_BIT_KR_FEC]    = resolved_kr_with_fec_q;
    bp_status[`ANPNS_BIT_KR]        = resolved_kr_q;
    bp_status[`ANPNS_BIT_KX]        = resolved_kx_q;
    bp_status[`ANPNS_BIT_CAPABLE]   = 1'b1;
  end

  // read mux, unmapped addresses answer zero
  always @* begin
    next_rd_data = 16'h0000;
    if (hit_word0) begin
      next_rd_data = pnp_word0;
    end else if (hit_word1) begin
      next_rd_data = pnp_snap1;
    end else if (hit_word2) begin
      next_rd_data = pnp_snap2;
    end else if (hit_status) begin
      next_rd_data = bp_status;
    end
  end

  // address moves on address frames and post-increment reads only
  always @* begin
    next_mmd_addr = mmd_addr;
    if (post_inc) begin
      next_mmd_addr = mmd_addr + 16'h0001;
    end else if (addr_frame) begin
      next_mmd_addr = cmd_data;
    end
  end

  always @(posedge clk) begin
    if (sys_rst) begin
      mmd_addr <= `ANPNS_RST_ADDR;
    end else begin
      mmd_addr <= next_mmd_addr;
    end
  end

  // read answer taken after the header, from the old address
  always @(posedge clk) begin
    if (sys_rst) begin
      rd_data <= 16'h0000;
    end else if (rd_req) begin
      rd_data <= next_rd_data;
    end
  end

  // a read of the first word freezes the other two
  always @(posedge clk) begin
    if (sys_rst) begin
      pnp_snap1 <= `ANPNS_RST_PNP;
      pnp_snap2 <= `ANPNS_RST_PNP;
    end else if (rd_req && hit_word0) begin
      pnp_snap1 <= pnp_word1;
      pnp_snap2 <= pnp_word2;
    end
  end

  // outgoing next page header bits
  always @(posedge clk) begin
    if (sys_rst) begin
      tx_more_pages <= 1'b0;
      tx_toggle     <= 1'b0;
    end else begin
      tx_more_pages <= local_more_pages_flag;
      tx_toggle     <= next_tx_toggle;
    end
  end

  // toggle made here, flips once per sent page
  always @* begin
    next_tx_toggle = tx_toggle;
    if (tx_page_sent) begin
      next_tx_toggle = ~tx_toggle;
    end
  end

endmodule

`default_nettype wire

// ==== anpns_top_test.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "anpns_defines.vh"
module anpns_top_test;
  logic        clk, sys_rst, mdc, mdio_in, mdio_out, mdio_oe, rx_page_valid;
  logic        fec, kr, kx, lmp, tx_page_sent, tx_more_pages, tx_toggle;
  logic [47:0] rx_page;
  logic [47:0] pg [2];
  logic [15:0] r;
  int          failures, total_checks, cyc;

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  anpns_top i_dut (
    .clk(clk), .sys_rst(sys_rst), .mdc(mdc), .mdio_in(mdio_in), .mdio_out(mdio_out),
    .mdio_oe(mdio_oe), .rx_page_valid(rx_page_valid), .rx_page(rx_page),
    .resolved_kr_with_fec(fec), .resolved_kr(kr), .resolved_kx(kx),
    .local_more_pages_flag(lmp), .tx_page_sent(tx_page_sent),
    .tx_more_pages(tx_more_pages), .tx_toggle(tx_toggle)
  );
  anpns_host i_host (
    .clk(clk), .mdio_out(mdio_out), .mdio_oe(mdio_oe), .mdc(mdc), .mdio_in(mdio_in)
  );

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic xfer(input logic [1:0] op, input logic [15:0] d);
    i_host.frame(op, `ANPNS_DEVAD, d, r);
  endtask

  task automatic rd(input logic [15:0] a);
    xfer(`ANPNS_OP_ADDR, a);
    xfer(`ANPNS_OP_READ, 16'h0000);
  endtask

  task automatic load(input logic [47:0] p);
    @(posedge clk);
    rx_page <= p;
    rx_page_valid <= 1'b1;
    @(posedge clk);
    rx_page_valid <= 1'b0;
  endtask

  task automatic end_sim;
    $display("checks=%0d failures=%0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cyc++;
    if (cyc == 60000) begin
      failures++;
      end_sim();
    end
  end

  initial begin
    {sys_rst, rx_page_valid, fec, kr, kx, lmp, tx_page_sent} = 7'h40;
    rx_page = 48'h0;
    pg[0] = 48'hbeef_c0de_a5c3;
    pg[1] = ~pg[0];
    repeat (6) @(posedge clk);
    sys_rst <= 1'b0;
    rd(`ANPNS_OFS_BP_STATUS);
    chk(r, `ANPNS_RST_BP_STATUS);
    rd(`ANPNS_OFS_PNP_WORD1);
    chk(r, `ANPNS_RST_PNP);
    for (int k = 0; k < 2; k++) begin
      load(pg[k]);
      xfer(`ANPNS_OP_ADDR, `ANPNS_OFS_PNP_WORD0);
      xfer(`ANPNS_OP_RDINC, 16'h0000);
      chk(r, pg[k][15:0]);
      // a newer page must not leak into the snapshot
      load(pg[1-k]);
      xfer(`ANPNS_OP_RDINC, 16'h0000);
      chk(r, pg[k][31:16]);
      xfer(`ANPNS_OP_READ, 16'h0000);
      chk(r, pg[k][47:32]);
    end
    xfer(`ANPNS_OP_ADDR, `ANPNS_OFS_PNP_WORD0);
    xfer(`ANPNS_OP_WRITE, 16'hffff);
    xfer(`ANPNS_OP_READ, 16'h0000);
    chk(r, pg[0][15:0]);
    for (int s = 0; s < 8; s++) begin
      @(posedge clk);
      {fec, kr, kx} <= s[2:0];
      rd(`ANPNS_OFS_BP_STATUS);
      chk(r, {11'h000, s[2], s[1], 1'b0, s[0], 1'b1});
    end
    // mid-run reset clears captured words and the snapshot
    @(posedge clk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    rd(`ANPNS_OFS_PNP_WORD1);
    chk(r, `ANPNS_RST_PNP);
    rd(`ANPNS_OFS_PNP_WORD0);
    chk(r, `ANPNS_RST_PNP);
    rd(16'h0031);
    chk(r, 16'h0000);
    i_host.frame(`ANPNS_OP_READ, 5'h01, 16'h0000, r);
    chk(r, 16'hffff);
    for (int k = 0; k < 2; k++) begin
      @(posedge clk);
      lmp <= k[0];
      tx_page_sent <= 1'b1;
      @(posedge clk);
      tx_page_sent <= 1'b0;
      @(posedge clk);
      #1;
      chk({15'h0000, tx_toggle}, {15'h0000, ~k[0]});
      chk({15'h0000, tx_more_pages}, {15'h0000, k[0]});
    end
    end_sim();
  end
endmodule
`default_nettype wire
